// ---- verilog/ushm_sched_map.sv ----
// What this block does
// - word window at 0xE0032400, four-byte stride
// - both entry views share one storage
// - scratch section is hardware only
// - each section holds 32 three-word entries
// - lower x400-x57C, upper x580-x6FC
// - upper entry fields at fixed positions
// - low word fields at fixed positions
// - internal flags report handshakes, phase, completion
// - shape code picks control phase order
// - multiplier decrements on success down to zero, else restored
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module ushm_sched_map
(
  // clock and reset
  input  wire logic                         SYS_CLK_I,
  input  wire logic                         RST_I,
  // apb slave
  input  wire logic                         PSEL_I,
  input  wire logic                         PENABLE_I,
  input  wire logic                         PWRITE_I,
  input  wire logic [ushm_pkg::ADDR_W-1:0] PADDR_I,
  input  wire logic [ushm_pkg::DATA_W-1:0] PWDATA_I,
  output logic      [ushm_pkg::DATA_W-1:0] PRDATA_O,
  output logic                              PREADY_O,
  output logic                              PSLVERR_O,
  // scheduler engine, same clock
  input  wire logic [5:0]                   ENG_EP_I,
  input  wire logic                         ENG_DONE_I,
  input  wire logic                         ENG_OK_I,
  input  wire logic [ushm_pkg::IDX_W-1:0]  ENG_RD_IDX_I,
  output logic      [ushm_pkg::DATA_W-1:0] ENG_RD_DATA_O,
  // handshake and frame results
  input  wire logic [3:0]                   HS_EVT_I,
  input  wire logic                         FRAME_FIT_I,
  // control endpoint phasing
  input  wire logic                         CTL_START_I,
  input  wire logic                         CTL_STEP_I,
  // schedule side indications
  input  wire logic                         PERI_SIDE_I,
  input  wire logic                         ASYNC_SIDE_I,
  // interrupt
  output logic                              IRQ_O
);
  import ushm_pkg::*;

  // byte offset to word index inside a window
  function automatic logic [IDX_W-1:0] win_index(input logic [ADDR_W-1:0] off,
                                                   input logic [ADDR_W-1:0] base);
    logic [ADDR_W-1:0] d;
    d = off - base;
    return d[9:2];
  endfunction : win_index

  // word index of an entry's first word
  function automatic logic [IDX_W-1:0] entry_base(input logic [5:0] ep);
    logic [IDX_W-1:0] sec;
    sec = ep[5] ? SEC_WORDS : 8'h00;
    return IDX_W'(sec + IDX_W'(ep[4:0]) * ENTRY_WORDS);
  endfunction : entry_base

  // true when the word is the low word of an entry
  function automatic logic is_low_word(input logic [IDX_W-1:0] idx);
    return IDX_W'(idx % ENTRY_WORDS) == 8'h00;
  endfunction : is_low_word

  // bus decode
  logic              acc;        // access phase
  logic              hit_prim;   // lower or upper section
  logic              hit_alias;  // second format view
  logic              hit_mem;    // any storage view
  logic              hit_reg;    // control or status word
  logic [IDX_W-1:0]  bus_idx;    // storage index of bus access
  logic              bus_wr;     // completed storage write
  logic              reg_wr;     // completed register write

  // storage ports
  logic              mem_wr;
  logic [IDX_W-1:0]  mem_wr_idx;
  logic [DATA_W-1:0] mem_wr_data;
  logic [DATA_W-1:0] mem_a_data;
  logic [IDX_W-1:0]  eng_idx;
  logic [DATA_W-1:0] eng_word;

  // multiplier handling
  logic [1:0]        mul_old;    // multiplier as stored now
  logic [1:0]        mul_new;    // multiplier after the update
  logic [1:0]        scratch_mul [2 * SEC_EPS]; // hardware-only originals
  logic [5:0]        bus_ep;     // entry of a bus write

  // flags, interrupts and control phasing
  logic [8:0]        flags;
  logic [8:0]        next_flags;
  logic [2:0]        phase;
  logic              seq_done;
  logic              cmp_evt;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_en;
  logic [IRQ_W-1:0]  irq_evt;
  logic [DATA_W-1:0] rd_mux;

  // window decode; the scratch words have no address at all
  assign acc       = PSEL_I && PENABLE_I;
  assign hit_prim  = PADDR_I >= OFF_LOWER_LO && PADDR_I <= OFF_UPPER_HI;
  assign hit_alias = PADDR_I >= OFF_ALIAS_LO && PADDR_I <= OFF_ALIAS_HI;
  assign hit_mem   = (hit_prim || hit_alias) && PADDR_I[1:0] == 2'h0;
  // both views fold onto one index range
  assign bus_idx   = hit_alias ? win_index(PADDR_I, OFF_ALIAS_LO)
                               : win_index(PADDR_I, OFF_LOWER_LO);
  assign hit_reg   = PADDR_I == OFF_FLAGS || PADDR_I == OFF_IRQ_STAT ||
                     PADDR_I == OFF_IRQ_EN || PADDR_I == OFF_IRQ_CLR ||
                     PADDR_I == OFF_CTRL;

  // the engine update owns the write port, so the bus waits a cycle
  assign PREADY_O  = !ENG_DONE_I;
  // unmapped offsets answer with an error, nothing changes
  assign PSLVERR_O = acc && PREADY_O && !(hit_mem || hit_reg);
  assign bus_wr    = acc && PREADY_O && PWRITE_I && hit_mem;
  assign reg_wr    = acc && PREADY_O && PWRITE_I && hit_reg;

  // engine port: update target first, then shape fetch, else free read
  always_comb
  begin
    if (ENG_DONE_I)
      eng_idx = entry_base(ENG_EP_I);
    else if (CTL_START_I)
      eng_idx = IDX_W'(entry_base(ENG_EP_I) + 8'h01);
    else
      eng_idx = ENG_RD_IDX_I;
  end

  // multiplier sits in the low word of the entry
  assign mul_old = eng_word[MUL_LSB +: 2];

  // success counts down to zero and holds there, failure reloads the programmed value
  always_comb
  begin
    if (!ENG_OK_I)
      mul_new = scratch_mul[ENG_EP_I];
    else if (mul_old != 2'h0)
      mul_new = mul_old - 2'h1;
    else
      mul_new = mul_old;
  end

  // write port mux
  always_comb
  begin
    if (ENG_DONE_I)
    begin
      mem_wr      = 1'b1;
      mem_wr_idx  = eng_idx;
      mem_wr_data = eng_word;
      mem_wr_data[MUL_LSB +: 2] = mul_new;
    end
    else
    begin
      mem_wr      = bus_wr;
      mem_wr_idx  = bus_idx;
      mem_wr_data = PWDATA_I;
    end
  end

  // entry number of a bus write, section then endpoint
  assign bus_ep = {bus_idx >= SEC_WORDS,
                   5'(IDX_W'(bus_idx >= SEC_WORDS ? bus_idx - SEC_WORDS : bus_idx)
                      / ENTRY_WORDS)};

  // scratch copy of the programmed multiplier, never bus readable
  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      for (int i = 0; i < 2 * SEC_EPS; i++)
        scratch_mul[i] <= 2'h0;
    end
    else if (bus_wr && is_low_word(bus_idx))
      scratch_mul[bus_ep] <= PWDATA_I[MUL_LSB +: 2];
  end

  // shared storage
  ushm_store ushm_store_inst (
    .clk_i     (SYS_CLK_I),
    .rst_i     (RST_I),
    .wr_en_i   (mem_wr),
    .wr_idx_i  (mem_wr_idx),
    .wr_data_i (mem_wr_data),
    .a_idx_i   (bus_idx),
    .a_data_o  (mem_a_data),
    .b_idx_i   (eng_idx),
    .b_data_o  (eng_word)
  );

  // control transfer phasing, shape taken from the entry
  ushm_ctl_seq ushm_ctl_seq_inst (
    .clk_i   (SYS_CLK_I),
    .rst_i   (RST_I),
    .start_i (CTL_START_I),
    .step_i  (CTL_STEP_I),
    .shape_i (eng_word[SHAPE_W1_LSB +: 2]),
    .phase_o (phase),
    .done_o  (seq_done)
  );

  // engine read data from a flop
  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      ENG_RD_DATA_O <= ENTRY_RST;
    else
      ENG_RD_DATA_O <= eng_word;
  end

  // completion from a good transfer or a finished control sequence
  assign cmp_evt = (ENG_DONE_I && ENG_OK_I) || seq_done;

  // sticky bits: software may write, a hardware set always wins
  always_comb
  begin
    next_flags = flags;
    if (reg_wr && PADDR_I == OFF_FLAGS)
      next_flags = PWDATA_I[8:0];
    next_flags[FLG_HS_LSB +: 4] = next_flags[FLG_HS_LSB +: 4] | HS_EVT_I;
    next_flags[FLG_DONE] = next_flags[FLG_DONE] | cmp_evt;
    // phase and fit are live, not stored
    next_flags[FLG_PH_LSB +: 3] = phase;
    next_flags[FLG_FIT] = FRAME_FIT_I;
  end

  // internal flags register
  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      flags <= FLAGS_RST;
    else
      flags <= next_flags;
  end

  // interrupt events: handshakes in the low bits, completion on top
  assign irq_evt = {cmp_evt, HS_EVT_I};

  // interrupt status, write one to clear, set beats clear
  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      irq_stat <= IRQ_RST;
    else if (reg_wr && PADDR_I == OFF_IRQ_CLR)
      irq_stat <= (irq_stat & ~PWDATA_I[IRQ_W-1:0]) | irq_evt;
    else
      irq_stat <= irq_stat | irq_evt;
  end

  // interrupt enable
  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      irq_en <= IRQ_RST;
    else if (reg_wr && PADDR_I == OFF_IRQ_EN)
      irq_en <= PWDATA_I[IRQ_W-1:0];
  end

  // level interrupt from a flop
  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      IRQ_O <= 1'b0;
    else
      IRQ_O <= |(irq_stat & irq_en);
  end

  // read mux; the clear word and unmapped offsets read zero
  always_comb
  begin
    rd_mux = '0;
    if (hit_mem)
      rd_mux = mem_a_data;
    else if (PADDR_I == OFF_FLAGS)
      rd_mux = {23'h0, flags};
    else if (PADDR_I == OFF_IRQ_STAT)
      rd_mux = {27'h0, irq_stat};
    else if (PADDR_I == OFF_IRQ_EN)
      rd_mux = {27'h0, irq_en};
    else if (PADDR_I == OFF_CTRL)
      rd_mux = {30'h0, ASYNC_SIDE_I, PERI_SIDE_I};
  end

  // read data caught in setup and in stalled access cycles;
  // a read racing an engine update returns the older word
  always_ff @(posedge SYS_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      PRDATA_O <= '0;
    else if (PSEL_I && !(PENABLE_I && PREADY_O) && !PWRITE_I)
      PRDATA_O <= rd_mux;
  end

  win_base_a: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (acc && PREADY_O && (PADDR_I == OFF_LOWER_LO || PADDR_I == OFF_UPPER_HI))
      |-> !PSLVERR_O && hit_mem)
    else $error("section boundary word not mapped");

  scratch_hidden_a: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (acc && PREADY_O && PADDR_I == 12'h700) |-> PSLVERR_O)
    else $error("word past upper section is reachable");

  entry_stride_a: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    ENG_DONE_I |-> mem_wr_idx == IDX_W'(ENG_EP_I * 8'h03))
    else $error("entry address not base plus three words");

  mul_dec_a: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (ENG_DONE_I && ENG_OK_I && mul_old == 2'h2)
      |-> mem_wr && mem_wr_data[MUL_LSB +: 2] == 2'h1)
    else $error("multiplier not counted down");

  mul_restore_a: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (ENG_DONE_I && !ENG_OK_I)
      |-> mem_wr_data[MUL_LSB +: 2] == scratch_mul[ENG_EP_I])
    else $error("multiplier not restored");

  hs_sticky_a: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    HS_EVT_I[3] |=> flags[8] && irq_stat[3])
    else $error("stall handshake not recorded");

  irq_level_a: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (irq_en[4] && cmp_evt) |=> ##1 IRQ_O)
    else $error("enabled completion raised no interrupt");

  done_sticky_a: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    cmp_evt |=> flags[FLG_DONE])
    else $error("endpoint completion not recorded");

  eng_stall_a: assert property (
    @(posedge SYS_CLK_I) disable iff (RST_I)
    (acc && ENG_DONE_I) |-> !PREADY_O && !bus_wr && !reg_wr)
    else $error("bus access not held off during engine update");
endmodule : ushm_sched_map

// ---- verilog/ushm_pkg.sv ----
package ushm_pkg;
  // bus geometry
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam int          IDX_W         = 8;
  // block base and documented window numbering
  localparam logic [31:0] BLOCK_BASE    = 32'he0032000;
  localparam logic [31:0] WIN_BASE      = 32'he0032400;
  localparam int          WIN_COUNT     = 64;
  localparam logic [11:0] WIN_STRIDE    = 12'h004;
  // storage windows, byte offsets in the block
  localparam logic [11:0] OFF_LOWER_LO  = 12'h400;
  localparam logic [11:0] OFF_LOWER_HI  = 12'h57c;
  localparam logic [11:0] OFF_UPPER_LO  = 12'h580;
  localparam logic [11:0] OFF_UPPER_HI  = 12'h6fc;
  localparam logic [11:0] OFF_ALIAS_LO  = 12'h800;
  localparam logic [11:0] OFF_ALIAS_HI  = 12'hafc;
  // control and status registers
  localparam logic [11:0] OFF_FLAGS     = 12'h084;
  localparam logic [11:0] OFF_IRQ_STAT  = 12'h0a0;
  localparam logic [11:0] OFF_IRQ_EN    = 12'h0a4;
  localparam logic [11:0] OFF_IRQ_CLR   = 12'h0a8;
  localparam logic [11:0] OFF_CTRL      = 12'h0b0;
  // storage shape
  localparam int          MEM_WORDS     = 192;
  localparam int          SEC_EPS       = 32;
  localparam logic [7:0]  SEC_WORDS     = 8'h60;
  localparam logic [7:0]  ENTRY_WORDS   = 8'h03;
  // entry fields, bit positions within the 96-bit entry
  localparam int          CMPL_RATE_LSB = 81;
  localparam int          MODE_BIT      = 80;
  localparam int          BYTES_LSB     = 64;
  localparam int          SHAPE_LSB     = 62;
  localparam int          BYPASS_BIT    = 61;
  localparam int          XMULT_LSB     = 59;
  localparam int          RESP_LSB      = 51;
  localparam int          POLL_LSB      = 43;
  localparam int          MAXPKT_LSB    = 32;
  localparam int          SMASK_LSB     = 24;
  localparam int          PING_BIT      = 23;
  localparam int          RELOAD_LSB    = 19;
  localparam int          MUL_LSB       = 17;
  localparam int          ISO_BIT       = 16;
  localparam int          RETRY_LSB     = 14;
  localparam int          NAKC_LSB      = 10;
  localparam int          ZLEN_BIT      = 7;
  localparam int          EPTYPE_LSB    = 5;
  localparam int          EPNUM_LSB     = 0;
  localparam logic [31:0] ENTRY_RST     = 32'h0000_0000;
  // shape field inside the entry's middle word
  localparam int          SHAPE_W1_LSB  = 30;
  // internal flags layout
  localparam int          FLG_HS_LSB    = 5;
  localparam int          FLG_PH_LSB    = 2;
  localparam int          FLG_FIT       = 1;
  localparam int          FLG_DONE      = 0;
  localparam logic [8:0]  FLAGS_RST     = 9'h001;
  // interrupt events: four handshakes plus completion
  localparam int          IRQ_W         = 5;
  localparam logic [4:0]  IRQ_RST       = 5'h00;
  // control transfer shapes
  localparam logic [1:0]  SHAPE_RSVD    = 2'h0;
  localparam logic [1:0]  SHAPE_OUT_IN  = 2'h1;
  localparam logic [1:0]  SHAPE_IN_OUT  = 2'h2;
  localparam logic [1:0]  SHAPE_NODATA  = 2'h3;
endpackage : ushm_pkg

// ---- verilog/ushm_store.sv ----
`timescale 1ns/1ps
module ushm_store
(
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // single write port
  input  wire logic                         wr_en_i,
  input  wire logic [ushm_pkg::IDX_W-1:0]  wr_idx_i,
  input  wire logic [ushm_pkg::DATA_W-1:0] wr_data_i,
  // read port a, bus side
  input  wire logic [ushm_pkg::IDX_W-1:0]  a_idx_i,
  output logic      [ushm_pkg::DATA_W-1:0] a_data_o,
  // read port b, engine side
  input  wire logic [ushm_pkg::IDX_W-1:0]  b_idx_i,
  output logic      [ushm_pkg::DATA_W-1:0] b_data_o
);
  import ushm_pkg::*;

  // one physical store behind every view
  logic [DATA_W-1:0] mem [MEM_WORDS];

  // flop array so every field resets to zero
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < MEM_WORDS; i++)
        mem[i] <= ENTRY_RST;
    end
    else if (wr_en_i)
      mem[wr_idx_i] <= wr_data_i;
  end

  // combinational reads; out of range reads as zero
  assign a_data_o = (a_idx_i < SEC_WORDS * 2) ? mem[a_idx_i] : ENTRY_RST;
  assign b_data_o = (b_idx_i < SEC_WORDS * 2) ? mem[b_idx_i] : ENTRY_RST;

  store_alias_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_en_i ##1 (a_idx_i == $past(wr_idx_i)) |-> a_data_o == $past(wr_data_i))
    else $error("stored word not visible on read");
endmodule : ushm_store

// ---- verilog/ushm_ctl_seq.sv ----
`timescale 1ns/1ps
module ushm_ctl_seq
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // control
  input  wire logic       start_i,
  input  wire logic       step_i,
  input  wire logic [1:0] shape_i,
  // status
  output logic      [2:0] phase_o,
  output logic            done_o
);
  import ushm_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_DOUT, ST_DIN, ST_SIN, ST_SOUT} ushm_ph_t;
  ushm_ph_t    state;   // current phase
  logic [1:0]  shape;   // latched shape

  // phase stepping per shape; reserved shape never starts
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state  <= ST_IDLE;
      shape  <= SHAPE_RSVD;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      unique case (state)
        ST_IDLE:
          if (start_i && shape_i != SHAPE_RSVD)
          begin
            state <= ST_SETUP;
            shape <= shape_i;
          end
        ST_SETUP:
          if (step_i)
            state <= (shape == SHAPE_OUT_IN) ? ST_DOUT :
                     (shape == SHAPE_IN_OUT) ? ST_DIN : ST_SIN;
        ST_DOUT: if (step_i) state <= ST_SIN;
        ST_DIN:  if (step_i) state <= ST_SOUT;
        ST_SIN, ST_SOUT:
          if (step_i)
          begin
            state  <= ST_IDLE;
            done_o <= 1'b1;
          end
      endcase
    end
  end

  // phase bits {in, out, setup}
  assign phase_o = {state == ST_DIN || state == ST_SIN,
                    state == ST_DOUT || state == ST_SOUT,
                    state == ST_SETUP};

  seq_start_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state == ST_IDLE && start_i && shape_i != SHAPE_RSVD) |=> phase_o == 3'h1)
    else $error("setup phase not entered on start");

  seq_order_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state == ST_DOUT && step_i) |=> phase_o == 3'h4)
    else $error("status after out data is not in");

  seq_reserved_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state == ST_IDLE && start_i && shape_i == SHAPE_RSVD) |=> phase_o == 3'h0)
    else $error("reserved shape started a control transfer");
endmodule : ushm_ctl_seq

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import ushm_pkg::*;
  // one expected bus result
  typedef struct {logic [31:0] d; logic [31:0] m; logic e; logic rd;} ushm_note_t;
  // clock, reset and apb master
  logic              clk, rst, psel, pen, pwr;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata, eng_data;
  logic              pready, pslverr, irq;
  // engine side stimulus
  logic [5:0]        eng_ep;
  logic              eng_done, eng_ok, fit, peri, asy, cst, cstp;
  logic [7:0]        eng_idx;
  logic [3:0]        hs;
  // bookkeeping
  ushm_note_t        notes[$];
  ushm_note_t        nt;
  int                failures = 0;
  int                n_checks = 0;
  logic [31:0]       seed = 32'hd7350d15;
  logic [31:0]       vals[5];
  logic [11:0]       offs[5] = '{12'h400, 12'h57c, 12'h580, 12'h6fc, 12'h444};
  logic [31:0]       w;

  ushm_sched_map ushm_sched_map_inst (.SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .ENG_EP_I(eng_ep), .ENG_DONE_I(eng_done),
    .ENG_OK_I(eng_ok), .ENG_RD_IDX_I(eng_idx), .ENG_RD_DATA_O(eng_data), .HS_EVT_I(hs),
    .FRAME_FIT_I(fit), .CTL_START_I(cst), .CTL_STEP_I(cstp), .PERI_SIDE_I(peri),
    .ASYNC_SIDE_I(asy), .IRQ_O(irq));

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer; the note is queued before the request goes out
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic e);
    int n;
    notes.push_back('{d: d, m: m, e: e, rd: !wr});
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= wr;
    paddr  <= a;
    pwdata <= wr ? d : 32'h0;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    psel <= 1'b0;
    pen  <= 1'b0;
    if (n == 50)
    begin
      failures++;
      report_and_stop();
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
    apb(1'b0, a, d, m, 1'b0);
  endtask : rd

  // one-cycle engine completion pulse
  task automatic eng(input logic [5:0] ep, input logic ok);
    @(posedge clk);
    eng_ep   <= ep;
    eng_ok   <= ok;
    eng_done <= 1'b1;
    @(posedge clk);
    eng_done <= 1'b0;
  endtask : eng

  // one-cycle pulse on handshake and phasing inputs
  task automatic strobe(input logic [5:0] v);
    @(posedge clk);
    {hs, cst, cstp} <= v;
    @(posedge clk);
    {hs, cst, cstp} <= 6'h00;
  endtask : strobe

  // bus monitor: oldest note against each completing access
  always @(negedge clk)
  begin
    if (psel && pen && pready === 1'b1)
    begin
      if (notes.size() == 0)
        chk("unexpected transfer", 32'h0, 32'h1);
      else
      begin
        nt = notes.pop_front();
        chk("pslverr", {31'h0, nt.e}, {31'h0, pslverr});
        if (nt.rd)
          chk("prdata", nt.d & nt.m, prdata & nt.m);
      end
    end
  end

  initial
  begin
    {rst, psel, pen, pwr, eng_done, eng_ok, fit, peri, asy, cst, cstp} = 11'h400;
    {paddr, pwdata, eng_ep, eng_idx, hs} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_LOWER_LO, ENTRY_RST, 32'hffffffff);
    rd(OFF_FLAGS, 32'h001, 32'h1ff);
    $display("test reset done");
    // section edges and an interior word at 0x444
    foreach (offs[i])
    begin
      vals[i] = rnd();
      wr(offs[i], vals[i]);
    end
    foreach (offs[i])
      rd(offs[i], vals[i], 32'hffffffff);
    @(posedge clk);
    eng_idx <= 8'h60;
    repeat (2) @(posedge clk);
    #1 chk("eng_rd_data", vals[2], eng_data);
    $display("test sections done");
    // second view shares storage both ways
    w = rnd();
    wr(OFF_ALIAS_LO + 12'h10c, w);
    rd(OFF_LOWER_LO + 12'h10c, w, 32'hffffffff);
    wr(OFF_UPPER_HI, ~w);
    rd(OFF_ALIAS_HI, ~w, 32'hffffffff);
    // scratch and holes refused
    apb(1'b0, 12'h700, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b1, 12'h700, w, 32'h0, 1'b1);
    apb(1'b0, 12'h402, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b0, 12'hb00, 32'h0, 32'hffffffff, 1'b1);
    rd(OFF_UPPER_HI, ~w, 32'hffffffff);
    $display("test views done");
    // multiplier: success decrements and holds at zero, failure restores
    wr(OFF_FLAGS, 32'h0);
    wr(OFF_IRQ_EN, 32'h10);
    w = (rnd() & ~32'h00060000) | 32'h00040000;
    wr(OFF_UPPER_LO + 12'h03c, w);
    for (int k = 0; k < 4; k++)
    begin
      eng(6'h25, k < 3);
      rd(OFF_UPPER_LO + 12'h03c, (w & ~32'h00060000) | ((k == 0 ? 32'h1 : k == 3 ? 32'h2 : 32'h0)
         << MUL_LSB), 32'hffffffff);
    end
    rd(OFF_FLAGS, 32'h1, 32'h1);
    rd(OFF_IRQ_STAT, 32'h10, 32'h1f);
    #1 chk("irq", 32'h1, {31'h0, irq});
    wr(OFF_IRQ_CLR, 32'h10);
    repeat (2) @(posedge clk);
    #1 chk("irq", 32'h0, {31'h0, irq});
    rd(OFF_IRQ_CLR, 32'h0, 32'hffffffff);
    wr(OFF_IRQ_EN, 32'h0);
    eng(6'h25, 1'b1);
    repeat (2) @(posedge clk);
    #1 chk("irq masked", 32'h0, {31'h0, irq});
    rd(OFF_IRQ_STAT, 32'h10, 32'h1f);
    wr(OFF_IRQ_EN, 32'h10);
    repeat (2) @(posedge clk);
    #1 chk("irq", 32'h1, {31'h0, irq});
    // a read stalled by an engine update returns the older word
    fork
      rd(OFF_UPPER_LO + 12'h03c, (w & ~32'h00060000) | (32'h1 << MUL_LSB), 32'hffffffff);
      begin
        @(posedge clk);
        eng(6'h25, 1'b1);
      end
    join
    rd(OFF_UPPER_LO + 12'h03c, w & ~32'h00060000, 32'hffffffff);
    wr(OFF_IRQ_CLR, 32'h1f);
    $display("test engine done");
    // each handshake lands in its own flag
    for (int i = 0; i < 4; i++)
    begin
      wr(OFF_FLAGS, 32'h0);
      wr(OFF_IRQ_CLR, 32'h1f);
      strobe({4'h1 << i, 2'b00});
      rd(OFF_FLAGS, 32'h20 << i, 32'h1e0);
      rd(OFF_IRQ_STAT, 32'h1 << i, 32'h1f);
    end
    // frame fit live and schedule side indications
    @(posedge clk);
    {fit, peri, asy} <= 3'b110;
    rd(OFF_FLAGS, 32'h2, 32'h2);
    rd(OFF_CTRL, 32'h1, 32'h3);
    {fit, peri, asy} <= 3'b001;
    rd(OFF_FLAGS, 32'h0, 32'h2);
    rd(OFF_CTRL, 32'h2, 32'h3);
    $display("test flags done");
    // every control shape, phases in order
    eng_ep <= 6'h00;
    for (int s = 0; s < 4; s++)
    begin
      wr(OFF_FLAGS, 32'h0);
      wr(OFF_LOWER_LO + 12'h004, {s[1:0], 30'h0});
      strobe(6'h02);
      rd(OFF_FLAGS, s == 0 ? 32'h0 : 32'h4, 32'h1c);
      if (s != 0)
      begin
        for (int k = 0; k < (s == 3 ? 1 : 2); k++)
        begin
          strobe(6'h01);
          rd(OFF_FLAGS, ((s == 1 && k == 0) || (s == 2 && k == 1)) ? 32'h8 : 32'h10,
             32'h1c);
        end
        strobe(6'h01);
        rd(OFF_FLAGS, 32'h1, 32'h1);
      end
    end
    $display("test shapes done");
    report_and_stop();
  end
endmodule : tb_top
